// ===== verilog/cwu_top.sv
/*
 * cwu_top: complementary waveform unit with shutdown, restart and the
 * control registers, reached over APB.
 * assumes: all source, fault and oscillator inputs are asynchronous pins;
 * the pad ring resolves out/oe into the pin level.
 */
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps

// Behaviour
// - writing flag one forces shutdown overrides
// - without auto-restart, shutdown lasts while flag set
// - auto-restart clears software flag, resume on rise
// - enabled fault input forces overrides promptly
// - level sensitive; fault holds shutdown until disabled
// - software clear ignored while enabled fault active
// - overrides stay until next source rising edge
// - auto-restart clears flag once faults inactive
// - override levels 11 and 10 unaffected by polarity
// - keeps running without processor clock dependence
// - request oscillator on when enabled, selected and source code valid
// - control 0 bit layout, bits 2-1 zero
// - polarity one inverts active waveform
// - output enable routes drive, else released
// - level codes 11 high, 10 low, 01 released
// - level 00 drives inactive level with polarity
// - source codes select pwm channels or comparator
// - shutdown control layout, unused bits zero
// - comparator high shuts down when enabled
// - fault pin low shuts down when enabled
// - rising edge: b off, a after dead band
// - unit disabled leaves pins undriven
module cwu_top (
	input  wire logic            I_CLK,     // 25 MHz clock
	input  wire logic            I_RESET,   // sync reset, high
	input  wire logic            I_PSEL,    // apb select
	input  wire logic            I_PENABLE, // apb enable
	input  wire logic            I_PWRITE,  // apb write
	input  wire logic [7:0]      I_PADDR,   // apb byte address
	input  wire logic [31:0]     I_PWDATA,  // apb write data
	output logic      [31:0]     O_PRDATA,  // apb read data
	output logic                 O_PREADY,  // apb ready
	output logic                 O_PSLVERR, // apb error
	input  wire logic [2:0]      I_PWM,     // pwm channels 3..1
	input  wire logic            I_CMP_RAW, // comparator raw output
	input  wire logic            I_FAULT_N, // fault pin, low active
	input  wire logic            I_OSC16,   // 16 MHz oscillator
	output cwu_pkg::cwu_pin_s    O_OUT_A,   // output a out/oe
	output cwu_pkg::cwu_pin_s    O_OUT_B,   // output b out/oe
	output logic                 O_OSC_KEEP // hold oscillator on
);
	import cwu_pkg::*;

	// ************************************************************
	// declarations
	// ************************************************************
	cwu_top_state_s st_reg;
	cwu_top_state_s st_next;

	logic       apb_setup;
	logic       apb_write;
	logic       fault;
	logic       src_sel;
	logic       src_valid;
	logic       tick;
	logic       shut;
	logic       db_rise;
	logic       act_a;
	logic       act_b;
	logic       cmp_s;
	logic       flt_n_s;
	logic       osc_s;
	logic [2:0] pwm_s;

	// ************************************************************
	// helper functions
	// ************************************************************
	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr == CWU_OFS_CTRL0) || (addr == CWU_OFS_CTRL1)
			|| (addr == CWU_OFS_SDCTRL) || (addr == CWU_OFS_DBRISE)
			|| (addr == CWU_OFS_DBFALL);
	endfunction

	function automatic logic [7:0] read_reg(input cwu_top_state_s s,
		input logic [7:0] addr);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
		CWU_OFS_CTRL0: begin
			v[CWU_C0_EN]   = s.c0.en;
			v[CWU_C0_OEB]  = s.c0.oe_b;
			v[CWU_C0_OEA]  = s.c0.oe_a;
			v[CWU_C0_POLB] = s.c0.pol_b;
			v[CWU_C0_POLA] = s.c0.pol_a;
			v[CWU_C0_CS]   = s.c0.clk_sel;
		end
		CWU_OFS_CTRL1: begin
			v[CWU_C1_LVLB +: 2] = s.c1.lvl_b;
			v[CWU_C1_LVLA +: 2] = s.c1.lvl_a;
			v[CWU_C1_SRC +: 3]  = s.c1.src;
		end
		CWU_OFS_SDCTRL: begin
			v[CWU_C2_FLAG] = s.c2.flag;
			v[CWU_C2_ARS]  = s.c2.ars;
			v[CWU_C2_CMP]  = s.c2.cmp_en;
			v[CWU_C2_FLT]  = s.c2.flt_en;
		end
		CWU_OFS_DBRISE: v = {2'b00, s.db_rise};
		CWU_OFS_DBFALL: v = {2'b00, s.db_fall};
		default: v = 8'h00;
		endcase
		read_reg = v;
	endfunction

	// one output pin: enable gate, override codes, polarity
	function automatic cwu_pin_s drive(input logic en,
		input logic pin_en, input logic pol, input logic [1:0] lvl,
		input logic sd, input logic act);
		cwu_pin_s p;
		p = '{out: 1'b0, oe: 1'b0};
		if (en && pin_en) begin
			p.oe = 1'b1;
			if (sd) begin
				case (lvl)
				CWU_LVL_HIGH: p.out = 1'b1;
				CWU_LVL_LOW:  p.out = 1'b0;
				CWU_LVL_TRI:  p.oe  = 1'b0;
				default:      p.out = pol;
				endcase
			end else begin
				p.out = act ^ pol;
			end
		end
		drive = p;
	endfunction

	// ************************************************************
	// synchronised inputs and source selection
	// ************************************************************
	// only the second stage is read; the first feeds nothing else
	assign pwm_s   = st_reg.sync2[2:0];
	assign cmp_s   = st_reg.sync2[3];
	assign flt_n_s = st_reg.sync2[4];
	assign osc_s   = st_reg.sync2[5];

	always_comb begin
		src_valid = 1'b1;
		case (st_reg.c1.src)
		CWU_SRC_PWM3: src_sel = pwm_s[2];
		CWU_SRC_PWM2: src_sel = pwm_s[1];
		CWU_SRC_PWM1: src_sel = pwm_s[0];
		CWU_SRC_CMP:  src_sel = cmp_s;
		default: begin
			// reserved codes give a quiet source
			src_sel   = 1'b0;
			src_valid = 1'b0;
		end
		endcase
	end

	// oscillator edges tick the dead band; else every system cycle
	assign tick = st_reg.c0.clk_sel ? (osc_s & ~st_reg.osc_prev)
		: 1'b1;

	assign fault = (st_reg.c2.cmp_en & cmp_s)
		| (st_reg.c2.flt_en & ~flt_n_s);

	assign shut = st_reg.c2.flag | st_reg.hold;

	// ************************************************************
	// dead-band engine
	// ************************************************************
	cwu_deadband u_deadband (
		.i_clk      (I_CLK),
		.i_reset    (I_RESET),
		.i_clear    (~st_reg.c0.en),
		.i_tick     (tick),
		.i_src      (src_sel),
		.i_rise_cnt (st_reg.db_rise),
		.i_fall_cnt (st_reg.db_fall),
		.o_rise     (db_rise),
		.o_act_a    (act_a),
		.o_act_b    (act_b)
	);

	// ************************************************************
	// apb slave
	// ************************************************************
	// read data is captured in the setup cycle, so no wait states
	assign apb_setup = I_PSEL & ~I_PENABLE;
	assign apb_write = I_PSEL & I_PENABLE & I_PWRITE;
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped(I_PADDR);
	assign O_PRDATA  = st_reg.prdata;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		st_next.sync1    = {I_OSC16, I_FAULT_N, I_CMP_RAW, I_PWM};
		st_next.sync2    = st_reg.sync1;
		st_next.osc_prev = osc_s;

		if (apb_setup) begin
			st_next.prdata = {24'h000000, read_reg(st_reg, I_PADDR)};
		end

		if (apb_write) begin
			case (I_PADDR)
			CWU_OFS_CTRL0: begin
				st_next.c0.en      = I_PWDATA[CWU_C0_EN];
				st_next.c0.oe_b    = I_PWDATA[CWU_C0_OEB];
				st_next.c0.oe_a    = I_PWDATA[CWU_C0_OEA];
				st_next.c0.pol_b   = I_PWDATA[CWU_C0_POLB];
				st_next.c0.pol_a   = I_PWDATA[CWU_C0_POLA];
				st_next.c0.clk_sel = I_PWDATA[CWU_C0_CS];
			end
			CWU_OFS_CTRL1: begin
				st_next.c1.lvl_b = I_PWDATA[CWU_C1_LVLB +: 2];
				st_next.c1.lvl_a = I_PWDATA[CWU_C1_LVLA +: 2];
				st_next.c1.src   = I_PWDATA[CWU_C1_SRC +: 3];
			end
			CWU_OFS_SDCTRL: begin
				st_next.c2.ars    = I_PWDATA[CWU_C2_ARS];
				st_next.c2.cmp_en = I_PWDATA[CWU_C2_CMP];
				st_next.c2.flt_en = I_PWDATA[CWU_C2_FLT];
				// a clear is refused while any enabled fault persists
				if (!I_PWDATA[CWU_C2_FLAG] && !fault) begin
					st_next.c2.flag = 1'b0;
				end
			end
			CWU_OFS_DBRISE: st_next.db_rise = I_PWDATA[5:0];
			CWU_OFS_DBFALL: st_next.db_fall = I_PWDATA[5:0];
			default: begin
			end
			endcase
		end

		// auto-restart drops the flag once every enabled fault source is quiet
		if (st_reg.c2.ars && !fault) begin
			st_next.c2.flag = 1'b0;
		end
		// setting always wins over any clear in the same cycle
		if (fault) begin
			st_next.c2.flag = 1'b1;
		end
		if (apb_write && I_PADDR == CWU_OFS_SDCTRL
			&& I_PWDATA[CWU_C2_FLAG]) begin
			st_next.c2.flag = 1'b1;
		end

		// overrides persist past the flag until a source rising edge
		if (st_reg.c2.flag) begin
			st_next.hold = 1'b1;
		end else if (db_rise) begin
			st_next.hold = 1'b0;
		end

		st_next.pin_a = drive(st_reg.c0.en, st_reg.c0.oe_a,
			st_reg.c0.pol_a, st_reg.c1.lvl_a, shut, act_a);
		st_next.pin_b = drive(st_reg.c0.en, st_reg.c0.oe_b,
			st_reg.c0.pol_b, st_reg.c1.lvl_b, shut, act_b);

		// runs on its own tick, nothing here waits on a cpu clock
		st_next.osc_keep = st_reg.c0.en & st_reg.c0.clk_sel
			& src_valid;
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			st_reg <= '{c0: {CWU_RST_CTRL0[7:3], CWU_RST_CTRL0[0]},
				c1: {CWU_RST_CTRL1[7:4], CWU_RST_CTRL1[2:0]},
				c2: {CWU_RST_SDCTRL[7:6], CWU_RST_SDCTRL[2:1]},
				db_rise: CWU_RST_DB, db_fall: CWU_RST_DB,
				sync1: 6'h10, sync2: 6'h10, osc_prev: 1'b0, hold: 1'b0,
				pin_a: '{out: 1'b0, oe: 1'b0},
				pin_b: '{out: 1'b0, oe: 1'b0},
				osc_keep: 1'b0, prdata: 32'h00000000};
		end else begin
			st_reg <= st_next;
		end
	end

	assign O_OUT_A    = st_reg.pin_a;
	assign O_OUT_B    = st_reg.pin_b;
	assign O_OSC_KEEP = st_reg.osc_keep;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RESET);

	sequence s_sd_write;
		apb_write && I_PADDR == CWU_OFS_SDCTRL;
	endsequence

	sequence s_flag_dropped;
		$fell(st_reg.c2.flag) ##0 !db_rise;
	endsequence

	a_sw_set_flag: assert property (
		s_sd_write ##0 I_PWDATA[CWU_C2_FLAG] |=> st_reg.c2.flag)
		else $error("flag not set by software write");

	a_noars_persist: assert property (
		st_reg.c2.flag && !st_reg.c2.ars && !(apb_write
		&& I_PADDR == CWU_OFS_SDCTRL) |=> st_reg.c2.flag)
		else $error("flag dropped without auto-restart");

	a_ars_clears: assert property (
		st_reg.c2.flag && st_reg.c2.ars && !fault
		&& !(apb_write && I_PADDR == CWU_OFS_SDCTRL)
		|=> !st_reg.c2.flag)
		else $error("auto-restart did not clear flag");

	a_fault_shut: assert property (
		fault |=> st_reg.c2.flag ##1 (!st_reg.pin_a.oe
		|| st_reg.c1.lvl_a != CWU_LVL_HIGH || st_reg.pin_a.out))
		else $error("fault did not force shutdown");

	a_clear_refused: assert property (
		s_sd_write ##0 !I_PWDATA[CWU_C2_FLAG] && fault
		|=> st_reg.c2.flag)
		else $error("flag cleared during active fault");

	a_hold_to_rise: assert property (
		s_flag_dropped |-> st_reg.hold && shut)
		else $error("override released before rising edge");

	a_override_lvl: assert property (
		shut && st_reg.c0.en && st_reg.c0.oe_b
		&& st_reg.c1.lvl_b == CWU_LVL_LOW
		|=> st_reg.pin_b.oe && !st_reg.pin_b.out)
		else $error("override level b wrong");

	a_disabled_quiet: assert property (
		!st_reg.c0.en |=> !st_reg.pin_a.oe && !st_reg.pin_b.oe)
		else $error("pins driven while unit disabled");

	a_polarity: assert property (
		!shut && st_reg.c0.en && st_reg.c0.oe_a
		|=> st_reg.pin_a.out == ($past(act_a) ^ $past(st_reg.c0.pol_a)))
		else $error("active polarity wrong on output a");

	a_tristate: assert property (
		shut && st_reg.c1.lvl_a == CWU_LVL_TRI |=> !st_reg.pin_a.oe)
		else $error("tri-state code still drives a");

endmodule // cwu_top

// ===== verilog/cwu_pkg.sv
/*
 * cwu_pkg: register map, field positions, reset values, codes and carrier
 * types of the complementary waveform unit.
 * assumes: a single 25 MHz clock domain; APB slave with 8-bit addresses.
 */
package cwu_pkg;

	// ************************************************************
	// register map and reset values
	// ************************************************************
	localparam logic [7:0] CWU_OFS_CTRL0  = 8'h00;
	localparam logic [7:0] CWU_OFS_CTRL1  = 8'h04;
	localparam logic [7:0] CWU_OFS_SDCTRL = 8'h08;
	localparam logic [7:0] CWU_OFS_DBRISE = 8'h0c;
	localparam logic [7:0] CWU_OFS_DBFALL = 8'h10;

	localparam logic [7:0] CWU_RST_CTRL0  = 8'h00;
	localparam logic [7:0] CWU_RST_CTRL1  = 8'h00;
	localparam logic [7:0] CWU_RST_SDCTRL = 8'h00;
	localparam logic [5:0] CWU_RST_DB     = 6'h00;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CWU_C0_EN    = 7;
	localparam int CWU_C0_OEB   = 6;
	localparam int CWU_C0_OEA   = 5;
	localparam int CWU_C0_POLB  = 4;
	localparam int CWU_C0_POLA  = 3;
	localparam int CWU_C0_CS    = 0;
	localparam int CWU_C1_LVLB  = 6;
	localparam int CWU_C1_LVLA  = 4;
	localparam int CWU_C1_SRC   = 0;
	localparam int CWU_C2_FLAG  = 7;
	localparam int CWU_C2_ARS   = 6;
	localparam int CWU_C2_CMP   = 2;
	localparam int CWU_C2_FLT   = 1;

	// ************************************************************
	// codes
	// ************************************************************
	localparam logic [1:0] CWU_LVL_HIGH = 2'h3;
	localparam logic [1:0] CWU_LVL_LOW  = 2'h2;
	localparam logic [1:0] CWU_LVL_TRI  = 2'h1;
	localparam logic [2:0] CWU_SRC_PWM3 = 3'h4;
	localparam logic [2:0] CWU_SRC_PWM2 = 3'h3;
	localparam logic [2:0] CWU_SRC_PWM1 = 3'h2;
	localparam logic [2:0] CWU_SRC_CMP  = 3'h0;

	// ************************************************************
	// types
	// ************************************************************
	typedef struct packed {
		logic out;
		logic oe;
	} cwu_pin_s;

	typedef struct packed {
		logic en;
		logic oe_b;
		logic oe_a;
		logic pol_b;
		logic pol_a;
		logic clk_sel;
	} cwu_ctrl0_s;

	typedef struct packed {
		logic [1:0] lvl_b;
		logic [1:0] lvl_a;
		logic [2:0] src;
	} cwu_ctrl1_s;

	typedef struct packed {
		logic flag;
		logic ars;
		logic cmp_en;
		logic flt_en;
	} cwu_ctrl2_s;

	typedef enum logic [2:0] {
		CWU_DB_OFF,
		CWU_DB_RISE,
		CWU_DB_A_ON,
		CWU_DB_FALL,
		CWU_DB_B_ON
	} cwu_db_e;

	typedef struct packed {
		cwu_db_e    st;
		logic [5:0] cnt;
		logic       src_prev;
		logic       act_a;
		logic       act_b;
	} cwu_db_state_s;

	typedef struct packed {
		cwu_ctrl0_s  c0;
		cwu_ctrl1_s  c1;
		cwu_ctrl2_s  c2;
		logic [5:0]  db_rise;
		logic [5:0]  db_fall;
		logic [5:0]  sync1;
		logic [5:0]  sync2;
		logic        osc_prev;
		logic        hold;
		cwu_pin_s    pin_a;
		cwu_pin_s    pin_b;
		logic        osc_keep;
		logic [31:0] prdata;
	} cwu_top_state_s;

endpackage

// ===== verilog/cwu_deadband.sv
/*
 * cwu_deadband: edge-driven dead-band engine producing the active drives
 * of outputs A and B from the selected input source.
 * assumes: i_src already synchronised; i_tick is a one-cycle unit clock.
 */
`timescale 1ns/1ps
module cwu_deadband (
	input  wire logic       i_clk,      // system clock
	input  wire logic       i_reset,    // synchronous reset, high
	input  wire logic       i_clear,    // unit disabled
	input  wire logic       i_tick,     // unit clock tick
	input  wire logic       i_src,      // selected input source
	input  wire logic [5:0] i_rise_cnt, // rising dead-band count
	input  wire logic [5:0] i_fall_cnt, // falling dead-band count
	output logic            o_rise,     // rising source edge pulse
	output logic            o_act_a,    // active drive A
	output logic            o_act_b     // active drive B
);
	import cwu_pkg::*;

	cwu_db_state_s state_reg;
	cwu_db_state_s state_next;
	logic          fall;

	function automatic logic cnt_done(input logic [5:0] cnt,
		input logic [5:0] lim);
		cnt_done = (7'(cnt) + 7'h01) >= {1'b0, lim};
	endfunction

	assign o_rise  = i_src & ~state_reg.src_prev;
	assign fall    = ~i_src & state_reg.src_prev;
	assign o_act_a = state_reg.act_a;
	assign o_act_b = state_reg.act_b;

	always_comb begin
		state_next = state_reg;
		state_next.src_prev = i_src;
		if (i_clear) begin
			state_next.st    = CWU_DB_OFF;
			state_next.act_a = 1'b0;
			state_next.act_b = 1'b0;
			state_next.cnt   = 6'h00;
		end else if (o_rise) begin
			// break before make: B off at the edge
			state_next.act_b = 1'b0;
			state_next.cnt   = 6'h00;
			state_next.act_a = (i_rise_cnt == 6'h00);
			state_next.st    = (i_rise_cnt == 6'h00) ? CWU_DB_A_ON
				: CWU_DB_RISE;
		end else if (fall) begin
			state_next.act_a = 1'b0;
			state_next.cnt   = 6'h00;
			state_next.act_b = (i_fall_cnt == 6'h00);
			state_next.st    = (i_fall_cnt == 6'h00) ? CWU_DB_B_ON
				: CWU_DB_FALL;
		end else begin
			case (state_reg.st)
			CWU_DB_RISE: begin
				if (i_tick) begin
					if (cnt_done(state_reg.cnt, i_rise_cnt)) begin
						state_next.act_a = 1'b1;
						state_next.st    = CWU_DB_A_ON;
					end else begin
						state_next.cnt = state_reg.cnt + 6'h01;
					end
				end
			end
			CWU_DB_FALL: begin
				if (i_tick) begin
					if (cnt_done(state_reg.cnt, i_fall_cnt)) begin
						state_next.act_b = 1'b1;
						state_next.st    = CWU_DB_B_ON;
					end else begin
						state_next.cnt = state_reg.cnt + 6'h01;
					end
				end
			end
			default: begin
			end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_reg <= '{st: CWU_DB_OFF, cnt: 6'h00, src_prev: 1'b0,
				act_a: 1'b0, act_b: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	a_break_first: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(o_rise && !i_clear) |=> !o_act_b)
		else $error("output b still on after rising edge");

endmodule // cwu_deadband

// ===== bench/cwu_switch_drv.sv
/*
 * cwu_switch_drv: gate drivers of the power switches behind output a and b.
 * assumes: pin structs come straight from the unit; a released pin is held
 * low by the driver's input pull-down, so a floating pin never turns on.
 */
`timescale 1ns/1ps
module cwu_switch_drv (
	input  wire cwu_pkg::cwu_pin_s i_pin_a,  // output a out/oe
	input  wire cwu_pkg::cwu_pin_s i_pin_b,  // output b out/oe
	output logic                   o_gate_a, // gate level of switch a
	output logic                   o_gate_b  // gate level of switch b
);
	import cwu_pkg::*;

	// ************************************************************
	// pin resolution
	// ************************************************************
	// pull-down wins while the unit releases the pin
	assign o_gate_a = i_pin_a.oe ? i_pin_a.out : 1'b0;
	assign o_gate_b = i_pin_b.oe ? i_pin_b.out : 1'b0;
endmodule // cwu_switch_drv

// ===== bench/testbench.sv
/*
 * testbench: register, shutdown, restart, source and dead-band checks of
 * the complementary waveform unit.
 * assumes: cwu_top answers apb with fewer than 20 wait cycles; pins seen via
 * cwu_switch_drv.
 */
`timescale 1ns/1ps
module testbench;
	import cwu_pkg::*;

	// ************************************************************
	// signals
	// ************************************************************
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  pwm;
	logic        cmp;
	logic        flt_n;
	logic        osc;
	cwu_pin_s    out_a;
	cwu_pin_s    out_b;
	logic        osc_keep;
	logic        gate_a;
	logic        gate_b;
	int          errors;
	int          checks_done;
	logic [1:0]  lv [4];
	logic [2:0]  sc [4];
	logic [31:0] q;
	logic        e;
	logic        p;

	always #20 clk = ~clk;
	// free-running, phase unrelated to clk
	always #31.25 osc = ~osc;

	cwu_top uut (
		.I_CLK     (clk),
		.I_RESET   (rst),
		.I_PSEL    (psel),
		.I_PENABLE (penable),
		.I_PWRITE  (pwrite),
		.I_PADDR   (paddr),
		.I_PWDATA  (pwdata),
		.O_PRDATA  (prdata),
		.O_PREADY  (pready),
		.O_PSLVERR (pslverr),
		.I_PWM     (pwm),
		.I_CMP_RAW (cmp),
		.I_FAULT_N (flt_n),
		.I_OSC16   (osc),
		.O_OUT_A   (out_a),
		.O_OUT_B   (out_b),
		.O_OSC_KEEP(osc_keep)
	);

	cwu_switch_drv drv_model (
		.i_pin_a (out_a),
		.i_pin_b (out_b),
		.o_gate_a(gate_a),
		.o_gate_b(gate_b)
	);

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic stop_test;
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rq, output logic re);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// no fixed latency assumed, only a bounded wait
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n == 20)
			errors++;
		rq = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rq;
		logic        re;
		apb(1'b1, a, d, rq, re);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] rq;
		logic        re;
		apb(1'b0, a, 32'h0, rq, re);
		check(rq, x);
	endtask

	function automatic logic [1:0] pv(input cwu_pin_s s);
		return {s.out & s.oe, s.oe};
	endfunction

	task automatic pins(input logic [1:0] ea, input logic [1:0] eb);
		check({30'h0, pv(out_a)}, {30'h0, ea});
		check({30'h0, pv(out_b)}, {30'h0, eb});
	endtask

	task automatic drv(input int i, input logic v);
		@(posedge clk);
		if (i < 3)
			pwm[i] <= v;
		else
			cmp <= v;
	endtask

	// fresh rising edge on pwm channel 1
	task automatic kick;
		drv(0, 1'b0);
		cyc(4);
		drv(0, 1'b1);
		cyc(6);
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		stop_test;
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		clk = 1'b0; osc = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0;
		pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; pwm = 3'h0;
		cmp = 1'b0; flt_n = 1'b1; errors = 0; checks_done = 0;
		lv = '{2'b11, 2'b00, 2'b01, 2'b11};
		sc = '{3'h2, 3'h3, 3'h4, 3'h0};
		cyc(4);
		rst <= 1'b0;
		rd(CWU_OFS_CTRL0, 32'h0);
		rd(CWU_OFS_CTRL1, 32'h0);
		rd(CWU_OFS_SDCTRL, 32'h0);
		wr(CWU_OFS_CTRL0, 32'h7f);
		rd(CWU_OFS_CTRL0, 32'h79);
		apb(1'b0, 8'h14, 32'h0, q, e);
		check({31'h0, e}, 32'h1);
		check(q, 32'h0);
		// configure disabled, start from shutdown
		wr(CWU_OFS_DBRISE, 32'h0);
		wr(CWU_OFS_SDCTRL, 32'hbf);
		rd(CWU_OFS_SDCTRL, 32'h86);
		wr(CWU_OFS_CTRL0, 32'hf8);
		for (int i = 0; i < 4; i++) begin
			wr(CWU_OFS_CTRL1, {24'h0, i[1:0], i[1:0], 4'h2});
			cyc(4);
			pins(lv[i], lv[i]);
		end
		wr(CWU_OFS_CTRL1, 32'ha2);
		wr(CWU_OFS_CTRL0, 32'he0);
		cyc(4);
		pins(2'b01, 2'b01);
		wr(CWU_OFS_SDCTRL, 32'h06);
		rd(CWU_OFS_SDCTRL, 32'h06);
		cyc(4);
		pins(2'b01, 2'b01);
		drv(0, 1'b1);
		cyc(6);
		pins(2'b11, 2'b01);
		drv(0, 1'b0);
		cyc(6);
		pins(2'b01, 2'b11);
		// each of the four selectable source codes, polarity alternating from code to code
		wr(CWU_OFS_SDCTRL, 32'h02);
		for (int i = 0; i < 4; i++) begin
			p = i[0];
			wr(CWU_OFS_CTRL0, {24'h0, 3'b111, p, p, 3'b000});
			wr(CWU_OFS_CTRL1, {24'h0, 5'h14, sc[i]});
			drv(i, 1'b1);
			cyc(6);
			pins({~p, 1'b1}, {p, 1'b1});
			drv(i, 1'b0);
			cyc(6);
			pins({p, 1'b1}, {~p, 1'b1});
		end
		// fault pin is level sensitive
		wr(CWU_OFS_CTRL0, 32'he0);
		wr(CWU_OFS_CTRL1, 32'ha2);
		kick;
		pins(2'b11, 2'b01);
		@(posedge clk);
		flt_n <= 1'b0;
		// two sync flops, flag, then the output register
		cyc(5);
		pins(2'b01, 2'b01);
		wr(CWU_OFS_SDCTRL, 32'h02);
		rd(CWU_OFS_SDCTRL, 32'h82);
		@(posedge clk);
		flt_n <= 1'b1;
		cyc(4);
		pins(2'b01, 2'b01);
		wr(CWU_OFS_SDCTRL, 32'h02);
		rd(CWU_OFS_SDCTRL, 32'h02);
		cyc(4);
		pins(2'b01, 2'b01);
		kick;
		pins(2'b11, 2'b01);
		// comparator shutdown with auto-restart
		wr(CWU_OFS_SDCTRL, 32'h44);
		drv(3, 1'b1);
		cyc(5);
		pins(2'b01, 2'b01);
		rd(CWU_OFS_SDCTRL, 32'hc4);
		drv(3, 1'b0);
		cyc(4);
		rd(CWU_OFS_SDCTRL, 32'h44);
		pins(2'b01, 2'b01);
		kick;
		pins(2'b11, 2'b01);
		wr(CWU_OFS_SDCTRL, 32'hc4);
		cyc(3);
		pins(2'b01, 2'b01);
		rd(CWU_OFS_SDCTRL, 32'h44);
		kick;
		pins(2'b11, 2'b01);
		// routing and module disable
		wr(CWU_OFS_CTRL0, 32'hc0);
		cyc(3);
		pins(2'b00, 2'b01);
		wr(CWU_OFS_CTRL0, 32'h60);
		cyc(3);
		pins(2'b00, 2'b00);
		// dead band timed by the oscillator: slower than system ticks
		wr(CWU_OFS_DBRISE, 32'h08);
		wr(CWU_OFS_CTRL0, 32'he1);
		cyc(3);
		check({31'h0, osc_keep}, 32'h1);
		kick;
		cyc(8);
		pins(2'b01, 2'b01);
		cyc(20);
		pins(2'b11, 2'b01);
		wr(CWU_OFS_CTRL1, 32'ha1);
		cyc(3);
		check({31'h0, osc_keep}, 32'h0);
		wr(CWU_OFS_CTRL1, 32'ha2);
		wr(CWU_OFS_CTRL0, 32'he0);
		cyc(3);
		check({31'h0, osc_keep}, 32'h0);
		// dead time as the gate drivers see it
		wr(CWU_OFS_DBRISE, 32'h0a);
		drv(0, 1'b0);
		cyc(20);
		drv(0, 1'b1);
		cyc(7);
		check({30'h0, gate_a, gate_b}, 32'h0);
		cyc(20);
		check({30'h0, gate_a, gate_b}, 32'h2);
		// falling dead band: a off at once, b after ten ticks
		wr(CWU_OFS_DBFALL, 32'h0a);
		rd(CWU_OFS_DBFALL, 32'h0a);
		drv(0, 1'b0);
		cyc(7);
		check({30'h0, gate_a, gate_b}, 32'h0);
		cyc(20);
		check({30'h0, gate_a, gate_b}, 32'h1);
		stop_test;
	end
endmodule // testbench
